// ==== core/hsq_pkg.sv ====
package hsq_pkg;
  // Speed command width shared by ports and carriers
  localparam int unsigned SPEED_W = 16;
  // Method numbers handled here
  localparam logic [7:0] METH_13 = 8'h0d;
  localparam logic [7:0] METH_14 = 8'h0e;
  localparam logic [7:0] METH_15 = 8'h0f;
  localparam logic [7:0] METH_16 = 8'h10;
  localparam logic [7:0] METH_17 = 8'h11;
  localparam logic [7:0] METH_18 = 8'h12;
  localparam logic [7:0] METH_19 = 8'h13;
  localparam logic [7:0] METH_20 = 8'h14;
  localparam logic [7:0] METH_21 = 8'h15;
  // Plan variants chosen at start
  localparam logic [1:0] VAR_OFF_POS = 2'h0;
  localparam logic [1:0] VAR_OFF_NEG = 2'h1;
  localparam logic [1:0] VAR_ON      = 2'h2;
  // Bit positions of the synchronised pin group
  localparam int unsigned PIN_W    = 4;
  localparam int unsigned HOME_BIT = 0;
  localparam int unsigned POS_BIT  = 1;
  localparam int unsigned NEG_BIT  = 2;
  localparam int unsigned IDX_BIT  = 3;

  typedef enum logic [2:0] {
    EV_HOME_RISE, EV_HOME_FALL, EV_NEG_ON, EV_POS_ON, EV_NEG_FALL, EV_POS_FALL
  } hsq_event_t;

  typedef struct packed {
    logic       dir_pos;
    logic       fast;
    hsq_event_t ev;
    logic       last;
    logic       use_index;
  } hsq_step_t;

  typedef struct packed {
    logic               run;
    logic               dir_pos;
    logic [SPEED_W-1:0] speed;
  } hsq_motion_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic alarm;
  } hsq_status_t;
endpackage : hsq_pkg

// ==== core/hsq_sync.sv ====
`timescale 1ns/1ps
module hsq_sync #(
  parameter int unsigned W = 4
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] pins,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] meta_q, meta_d, sync_q, sync_d, prev_q, prev_d;

  // First stage only feeds the second
  always_comb begin
    meta_d = clk_en ? pins : meta_q;
    sync_d = clk_en ? meta_q : sync_q;
    prev_d = clk_en ? sync_q : prev_q;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  // Edge flags per pin
  for (genvar i = 0; i < W; i++) begin : g_edge
    assign level[i] = sync_q[i];
    assign rise[i]  = sync_q[i] & ~prev_q[i];
    assign fall[i]  = ~sync_q[i] & prev_q[i];
  end
endmodule : hsq_sync

// ==== core/hsq_drive.sv ====
`timescale 1ns/1ps
module hsq_drive (
  input  wire logic                           sys_clk,
  input  wire logic                           rst_b,
  input  wire logic                           clk_en,
  input  wire logic                           run,
  input  wire logic                           dir_pos,
  input  wire logic                           fast,
  input  wire logic [hsq_pkg::SPEED_W-1:0]    fast_speed,
  input  wire logic [hsq_pkg::SPEED_W-1:0]    slow_speed,
  output hsq_pkg::hsq_motion_t                motion
);
  import hsq_pkg::*;
  hsq_motion_t motion_q, motion_d;

  // Zero speed when idle so the drive decelerates to a stop
  always_comb begin
    motion_d = motion_q;
    if (clk_en) begin
      motion_d.run     = run;
      motion_d.dir_pos = run & dir_pos;
      motion_d.speed   = !run ? '0 : (fast ? fast_speed : slow_speed);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      motion_q <= '0;
    end else begin
      motion_q <= motion_d;
    end
  end

  assign motion = motion_q;
endmodule : hsq_drive

// ==== core/hsq_homing.sv ====
`timescale 1ns/1ps
module hsq_homing (
  input  wire logic                        sys_clk,
  input  wire logic                        rst_b,
  input  wire logic                        clk_en,
  input  wire logic                        start,
  input  wire logic [7:0]                  method,
  input  wire logic                        origin_side_pos,
  input  wire logic                        home_switch,
  input  wire logic                        positive_limit,
  input  wire logic                        negative_limit,
  input  wire logic                        index_pulse,
  input  wire logic [hsq_pkg::SPEED_W-1:0] fast_speed,
  input  wire logic [hsq_pkg::SPEED_W-1:0] slow_speed,
  output hsq_pkg::hsq_motion_t             motion,
  output logic                             origin_set,
  output hsq_pkg::hsq_status_t             status
);
  import hsq_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_MOVE, ST_SEEK, ST_DONE, ST_ALARM} hsq_state_t;

  logic [PIN_W-1:0] lvl, rise, fall;
  hsq_state_t       state_q, state_d;
  logic [7:0]       meth_q, meth_d;
  logic [1:0]       var_q, var_d, step_q, step_d;
  logic             hit_q, hit_d, origin_q, origin_d;
  hsq_step_t        cur;
  logic             run, nl_rev, lim_abort;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edges
  hsq_sync #(.W(PIN_W)) u_sync (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .pins    ({index_pulse, negative_limit, positive_limit, home_switch}),
    .level   (lvl),
    .rise    (rise),
    .fall    (fall)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Step builder
  function automatic hsq_step_t mk(input logic p, input logic f, input hsq_event_t e,
                                   input logic l, input logic x);
    mk = '{dir_pos: p, fast: f, ev: e, last: l, use_index: x};
  endfunction : mk

  // Motion plan per method, variant and step
  function automatic hsq_step_t plan(input logic [7:0] m, input logic [1:0] v, input logic [1:0] s);
    plan = mk(1'b0, 1'b0, EV_HOME_FALL, 1'b1, 1'b0);
    case (m)
      METH_13: begin
        if (v == VAR_OFF_POS) begin
          plan = (s == 2'h0) ? mk(1'b0, 1'b0, EV_HOME_FALL, 1'b0, 1'b0)
                             : mk(1'b1, 1'b0, EV_HOME_RISE, 1'b1, 1'b1);
        end else if (v == VAR_OFF_NEG) begin
          case (s)
            2'h0:    plan = mk(1'b0, 1'b1, EV_NEG_ON, 1'b0, 1'b0);
            2'h1:    plan = mk(1'b1, 1'b1, EV_HOME_RISE, 1'b0, 1'b0);
            2'h2:    plan = mk(1'b0, 1'b1, EV_HOME_FALL, 1'b0, 1'b0);
            default: plan = mk(1'b1, 1'b0, EV_HOME_RISE, 1'b1, 1'b1);
          endcase
        end else begin
          plan = (s == 2'h0) ? mk(1'b0, 1'b1, EV_HOME_FALL, 1'b0, 1'b0)
                             : mk(1'b1, 1'b0, EV_HOME_RISE, 1'b1, 1'b1);
        end
      end
      METH_14: begin
        // Off-positive and on start share one path
        case (s)
          2'h0:    plan = (v == VAR_OFF_NEG) ? mk(1'b0, 1'b1, EV_NEG_ON, 1'b0, 1'b0)
                                             : mk(1'b0, 1'b1, EV_HOME_FALL, 1'b0, 1'b0);
          2'h1:    plan = mk(1'b1, 1'b1, EV_HOME_RISE, 1'b0, 1'b0);
          default: plan = mk(1'b0, 1'b0, EV_HOME_FALL, 1'b1, 1'b1);
        endcase
      end
      METH_17: begin
        if (v == VAR_ON || s != 2'h0) plan = mk(1'b1, 1'b0, EV_NEG_FALL, 1'b1, 1'b0);
        else plan = mk(1'b0, 1'b1, EV_NEG_ON, 1'b0, 1'b0);
      end
      METH_18: begin
        if (v == VAR_ON) plan = mk(1'b1, 1'b0, EV_POS_FALL, 1'b1, 1'b0);
        else if (s == 2'h0) plan = mk(1'b1, 1'b1, EV_POS_ON, 1'b0, 1'b0);
        else plan = mk(1'b0, 1'b0, EV_POS_FALL, 1'b1, 1'b0);
      end
      METH_19: begin
        if (v != VAR_ON) begin
          plan = (s == 2'h0) ? mk(1'b1, 1'b1, EV_HOME_RISE, 1'b0, 1'b0)
                             : mk(1'b0, 1'b0, EV_HOME_FALL, 1'b1, 1'b0);
        end else begin
          case (s)
            2'h0:    plan = mk(1'b0, 1'b1, EV_HOME_FALL, 1'b0, 1'b0);
            2'h1:    plan = mk(1'b1, 1'b1, EV_HOME_RISE, 1'b0, 1'b0);
            default: plan = mk(1'b0, 1'b0, EV_HOME_FALL, 1'b1, 1'b0);
          endcase
        end
      end
      METH_20: begin
        if (v != VAR_ON) begin
          case (s)
            2'h0:    plan = mk(1'b1, 1'b1, EV_HOME_RISE, 1'b0, 1'b0);
            2'h1:    plan = mk(1'b0, 1'b1, EV_HOME_FALL, 1'b0, 1'b0);
            default: plan = mk(1'b1, 1'b0, EV_HOME_RISE, 1'b1, 1'b0);
          endcase
        end else begin
          plan = (s == 2'h0) ? mk(1'b0, 1'b1, EV_HOME_FALL, 1'b0, 1'b0)
                             : mk(1'b1, 1'b0, EV_HOME_RISE, 1'b1, 1'b0);
        end
      end
      default: begin
        if (v != VAR_ON) begin
          plan = (s == 2'h0) ? mk(1'b0, 1'b1, EV_HOME_RISE, 1'b0, 1'b0)
                             : mk(1'b1, 1'b0, EV_HOME_FALL, 1'b1, 1'b0);
        end else begin
          case (s)
            2'h0:    plan = mk(1'b1, 1'b1, EV_HOME_FALL, 1'b0, 1'b0);
            2'h1:    plan = mk(1'b0, 1'b1, EV_HOME_RISE, 1'b0, 1'b0);
            default: plan = mk(1'b1, 1'b0, EV_HOME_FALL, 1'b1, 1'b0);
          endcase
        end
      end
    endcase
  endfunction : plan

  // Step end condition
  function automatic logic ev_hit(input hsq_event_t e, input logic [PIN_W-1:0] l,
                                  input logic [PIN_W-1:0] r, input logic [PIN_W-1:0] f);
    case (e)
      EV_HOME_RISE: ev_hit = r[HOME_BIT];
      EV_HOME_FALL: ev_hit = f[HOME_BIT];
      EV_NEG_ON:    ev_hit = l[NEG_BIT];
      EV_POS_ON:    ev_hit = l[POS_BIT];
      EV_NEG_FALL:  ev_hit = f[NEG_BIT];
      default:      ev_hit = f[POS_BIT];
    endcase
  endfunction : ev_hit

  // Reserved and out-of-range methods are refused
  function automatic logic supported(input logic [7:0] m);
    supported = (m == METH_13) || (m == METH_14) || (m >= METH_17 && m <= METH_21);
  endfunction : supported

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer
  assign cur       = plan(meth_q, var_q, step_q);
  assign run       = (state_q == ST_MOVE) || (state_q == ST_SEEK);
  assign nl_rev    = ((meth_q == METH_13) || (meth_q == METH_14)) && rise[NEG_BIT];
  assign lim_abort = (meth_q >= METH_19) && (lvl[POS_BIT] || lvl[NEG_BIT]);

  // Limit reactions take priority over step ends
  always_comb begin
    state_d  = state_q;
    meth_d   = meth_q;
    var_d    = var_q;
    step_d   = step_q;
    hit_d    = hit_q;
    origin_d = origin_q;
    if (clk_en) begin
      origin_d = 1'b0;
      case (state_q)
        ST_MOVE, ST_SEEK: begin
          if (lim_abort) begin
            state_d = ST_ALARM;
          end else if (nl_rev && hit_q) begin
            state_d = ST_ALARM;
          end else if (nl_rev) begin
            // Limit reversal joins the fast positive leg of the far-side path
            hit_d   = 1'b1;
            var_d   = VAR_OFF_NEG;
            step_d  = 2'h1;
            state_d = ST_MOVE;
          end else if (state_q == ST_SEEK) begin
            if (rise[IDX_BIT]) begin
              origin_d = 1'b1;
              state_d  = ST_DONE;
            end
          end else if (ev_hit(cur.ev, lvl, rise, fall)) begin
            if (!cur.last) begin
              step_d = step_q + 2'h1;
            end else if (cur.use_index) begin
              state_d = ST_SEEK;
            end else begin
              origin_d = 1'b1;
              state_d  = ST_DONE;
            end
          end
        end
        default: begin
          if (start) begin
            meth_d = method;
            step_d = 2'h0;
            hit_d  = 1'b0;
            if (!supported(method)) begin
              state_d = ST_ALARM;
            end else begin
              state_d = ST_MOVE;
              if (method == METH_17) var_d = lvl[NEG_BIT] ? VAR_ON : VAR_OFF_POS;
              else if (method == METH_18) var_d = lvl[POS_BIT] ? VAR_ON : VAR_OFF_POS;
              else if (lvl[HOME_BIT]) var_d = VAR_ON;
              else var_d = origin_side_pos ? VAR_OFF_POS : VAR_OFF_NEG;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q  <= ST_IDLE;
      meth_q   <= '0;
      var_q    <= VAR_OFF_POS;
      step_q   <= '0;
      hit_q    <= 1'b0;
      origin_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      meth_q   <= meth_d;
      var_q    <= var_d;
      step_q   <= step_d;
      hit_q    <= hit_d;
      origin_q <= origin_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Motion command and status
  hsq_drive u_drive (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .clk_en     (clk_en),
    .run        (run),
    .dir_pos    (cur.dir_pos),
    .fast       (cur.fast),
    .fast_speed (fast_speed),
    .slow_speed (slow_speed),
    .motion     (motion)
  );

  assign origin_set   = origin_q;
  assign status = '{busy:  run,
                    done:  (state_q == ST_DONE),
                    alarm: (state_q == ST_ALARM)};

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  logic go;
  assign go = clk_en && start && !run;

  property p_reserved;
    @(posedge sys_clk) disable iff (!rst_b) go && (method == METH_15 || method == METH_16) |=> status.alarm;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved method not refused");

  property p_m17_off;
    @(posedge sys_clk) disable iff (!rst_b) go && method == METH_17 && !lvl[NEG_BIT] && clk_en ##1 clk_en
      |=> motion.run && !motion.dir_pos && motion.speed == fast_speed;
  endproperty
  a_m17_off: assert property (p_m17_off) else $error("m17 first leg wrong");

  property p_m17_on;
    @(posedge sys_clk) disable iff (!rst_b) go && method == METH_17 && lvl[NEG_BIT] && clk_en ##1 clk_en
      |=> motion.dir_pos && motion.speed == slow_speed;
  endproperty
  a_m17_on: assert property (p_m17_on) else $error("m17 on-start leg wrong");

  property p_m18_off;
    @(posedge sys_clk) disable iff (!rst_b) go && method == METH_18 && !lvl[POS_BIT] && clk_en ##1 clk_en
      |=> motion.dir_pos && motion.speed == fast_speed;
  endproperty
  a_m18_off: assert property (p_m18_off) else $error("m18 first leg wrong");

  property p_m13_on;
    @(posedge sys_clk) disable iff (!rst_b) go && method == METH_13 && lvl[HOME_BIT] && clk_en ##1 clk_en
      |=> !motion.dir_pos && motion.speed == fast_speed;
  endproperty
  a_m13_on: assert property (p_m13_on) else $error("m13 on-start leg wrong");

  property p_m19_off;
    @(posedge sys_clk) disable iff (!rst_b) go && method == METH_19 && !lvl[HOME_BIT] && clk_en ##1 clk_en
      |=> motion.dir_pos && motion.speed == fast_speed;
  endproperty
  a_m19_off: assert property (p_m19_off) else $error("m19 first leg wrong");

  property p_limit_abort;
    @(posedge sys_clk) disable iff (!rst_b) clk_en && run && lim_abort |=> status.alarm ##1 !motion.run;
  endproperty
  a_limit_abort: assert property (p_limit_abort) else $error("limit did not abort");

  property p_second_nl;
    @(posedge sys_clk) disable iff (!rst_b) clk_en && run && nl_rev && hit_q && !lim_abort |=> status.alarm;
  endproperty
  a_second_nl: assert property (p_second_nl) else $error("second limit not alarmed");

  property p_done;
    @(posedge sys_clk) disable iff (!rst_b) origin_set |-> status.done && !$past(status.done);
  endproperty
  a_done: assert property (p_done) else $error("origin without completion");

  c_done:  cover property (@(posedge sys_clk) disable iff (!rst_b) origin_set);
  c_alarm: cover property (@(posedge sys_clk) disable iff (!rst_b) run ##1 status.alarm);
  c_seek:  cover property (@(posedge sys_clk) disable iff (!rst_b) state_q == ST_SEEK ##1 origin_set);
endmodule : hsq_homing

// ==== sim/hsq_axis_model.sv ====
`timescale 1ns/1ps
module hsq_axis_model (
  input  wire logic                 sys_clk,
  input  wire hsq_pkg::hsq_motion_t motion,
  input  wire logic                 origin_set,
  input  wire logic                 neg_force,
  input  wire logic                 pos_force,
  output logic                      home_switch,
  output logic                      positive_limit,
  output logic                      negative_limit,
  output logic                      index_pulse
);
  import hsq_pkg::*;
  // Axis geometry in encoder counts; index marks sit at 32 modulo 64
  localparam int HOME_LO = 0;
  localparam int HOME_HI = 200;
  localparam int NEG_END = -1000;
  localparam int POS_END = 1000;
  localparam int IDX_OFS = 32;
  int                 pos      = 0;
  int                 prev     = 0;
  int                 org_pos  = 0;
  int                 org_cnt  = 0;
  logic               last_dir = 1'b0;
  logic               org_dir  = 1'b0;
  logic [SPEED_W-1:0] last_spd = '0;
  logic [SPEED_W-1:0] org_spd  = '0;

  ////////////////////////////////////////////////////////////////////////
  // Travel: speed command taken as counts per cycle, no inertia
  always @(posedge sys_clk) begin
    prev <= pos;
    if (motion.run === 1'b1) begin
      pos      <= motion.dir_pos ? pos + int'(motion.speed) : pos - int'(motion.speed);
      last_dir <= motion.dir_pos;
      last_spd <= motion.speed;
    end
    // Snapshot of where and how the axis moved when origin was fixed
    if (origin_set === 1'b1) begin
      org_pos <= pos;
      org_dir <= last_dir;
      org_spd <= last_spd;
      org_cnt <= org_cnt + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pins follow position; forced levels stand in for a stray limit hit
  always_comb begin
    home_switch    = (pos >= HOME_LO) && (pos <= HOME_HI);
    negative_limit = (pos <= NEG_END) || neg_force;
    positive_limit = (pos >= POS_END) || pos_force;
    index_pulse    = ((pos - IDX_OFS) >>> 6) != ((prev - IDX_OFS) >>> 6);
  end

  // Only while idle, away from the edge, so travel never races it
  // Waits until the synchronisers hold the new levels, so no stale edge reaches a run
  task place(input int p);
    #1;
    pos     = p;
    prev    = p;
    org_cnt = 0;
    repeat (3) @(posedge sys_clk);
  endtask : place
endmodule : hsq_axis_model

// ==== sim/tb.sv ====
`timescale 1ns/1ps
module tb;
  import hsq_pkg::*;
  logic               sys_clk         = 1'b0;
  logic               rst_b           = 1'b0;
  logic               clk_en          = 1'b1;
  logic               start           = 1'b0;
  logic               origin_side_pos = 1'b0;
  logic               neg_force       = 1'b0;
  logic               pos_force       = 1'b0;
  logic [7:0]         method          = 8'h00;
  logic [SPEED_W-1:0] fast_speed      = 16'h0004;
  logic [SPEED_W-1:0] slow_speed      = 16'h0001;
  logic               home_switch;
  logic               positive_limit;
  logic               negative_limit;
  logic               index_pulse;
  logic               origin_set;
  hsq_motion_t        motion;
  hsq_status_t        status;
  int                 mismatches      = 0;
  int                 checked         = 0;
  int                 cycles          = 0;

  hsq_homing dut_u (.sys_clk, .rst_b, .clk_en, .start, .method, .origin_side_pos, .home_switch,
    .positive_limit, .negative_limit, .index_pulse, .fast_speed, .slow_speed, .motion, .origin_set, .status);
  hsq_axis_model ax_u (.sys_clk, .motion, .origin_set, .neg_force, .pos_force, .home_switch,
    .positive_limit, .negative_limit, .index_pulse);

  ////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; longest run is well under this ceiling
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Compares
  task chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bit
  task chk_spd(input logic [SPEED_W-1:0] got, input logic [SPEED_W-1:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_spd
  // Model positions and origin counts; tolerance covers synchroniser and stop latency
  task chk_int(input int got, input int exp, input int tol);
    checked++;
    if (got > exp + tol || got < exp - tol) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_int

  ////////////////////////////////////////////////////////////////////////
  // Shared drivers
  task go(input logic [7:0] m, input logic side);
    @(posedge sys_clk);
    method          <= m;
    origin_side_pos <= side;
    start           <= 1'b1;
    @(posedge sys_clk);
    start           <= 1'b0;
  endtask : go
  task wait_end;
    int n;
    n = 0;
    repeat (3) @(posedge sys_clk);
    while (status.done !== 1'b1 && status.alarm !== 1'b1 && n < 6000) begin
      @(posedge sys_clk);
      n++;
    end
    #1;
  endtask : wait_end
  // One homing run; poke issues a reserved method while busy
  task home_case(input logic [7:0] m, input int p, input logic side, input int exp, input logic dir,
                 input logic poke);
    ax_u.place(p);
    go(m, side);
    if (poke) begin
      repeat (10) @(posedge sys_clk);
      go(METH_15, 1'b0);
    end
    wait_end();
    chk_bit(status.done, 1'b1);
    chk_bit(status.alarm, 1'b0);
    repeat (2) @(posedge sys_clk);
    #1;
    chk_bit(motion.run, 1'b0);
    chk_spd(motion.speed, 16'h0000);
    chk_int(ax_u.org_pos, exp, 12);
    chk_bit(ax_u.org_dir, dir);
    chk_spd(ax_u.org_spd, slow_speed);
    chk_int(ax_u.org_cnt, 1, 0);
  endtask : home_case
  // Limit forced on after wc cycles of travel; abort expected
  task alarm_case(input logic [7:0] m, input int p, input logic side, input int wc, input logic fn,
                  input logic fp, input logic ed);
    ax_u.place(p);
    go(m, side);
    repeat (wc) @(posedge sys_clk);
    #1;
    chk_bit(status.alarm, 1'b0);
    chk_spd(motion.speed, fast_speed);
    chk_bit(motion.dir_pos, ed);
    neg_force <= fn;
    pos_force <= fp;
    repeat (4) @(posedge sys_clk);
    neg_force <= 1'b0;
    pos_force <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk_bit(status.alarm, 1'b1);
    chk_bit(status.done, 1'b0);
    wait_end();
    repeat (2) @(posedge sys_clk);
    #1;
    chk_bit(motion.run, 1'b0);
    chk_int(ax_u.org_cnt, 0, 0);
  endtask : alarm_case

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_reserved;
    for (int i = 0; i < 2; i++) begin
      ax_u.place(-300);
      go(i == 0 ? METH_15 : METH_16, 1'b0);
      repeat (3) @(posedge sys_clk);
      #1;
      chk_bit(status.alarm, 1'b1);
      chk_bit(motion.run, 1'b0);
    end
  endtask : t_reserved
  task t_m13;
    home_case(METH_13, 300, 1'b1, 32, 1'b1, 1'b0);
    home_case(METH_13, -300, 1'b0, 32, 1'b1, 1'b0);
    home_case(METH_13, 100, 1'b0, 32, 1'b1, 1'b0);
  endtask : t_m13
  task t_m14;
    home_case(METH_14, 300, 1'b1, -32, 1'b0, 1'b0);
    home_case(METH_14, -300, 1'b0, -32, 1'b0, 1'b0);
    home_case(METH_14, 100, 1'b0, -32, 1'b0, 1'b0);
  endtask : t_m14
  task t_m17_18;
    home_case(METH_17, -300, 1'b0, -1000, 1'b1, 1'b0);
    home_case(METH_17, -1010, 1'b0, -1000, 1'b1, 1'b0);
    home_case(METH_18, 300, 1'b0, 1000, 1'b0, 1'b0);
  endtask : t_m17_18
  // Limit on at start; the far side lets it go while the axis creeps positive
  task t_m18_on;
    pos_force <= 1'b1;
    ax_u.place(300);
    go(METH_18, 1'b0);
    repeat (20) @(posedge sys_clk);
    pos_force <= 1'b0;
    wait_end();
    chk_bit(status.done, 1'b1);
    chk_bit(ax_u.org_dir, 1'b1);
    chk_spd(ax_u.org_spd, slow_speed);
    chk_int(ax_u.org_pos, 320, 12);
  endtask : t_m18_on
  // Enable low across the home edge: command holds, run resumes and ends afterwards
  task t_freeze;
    ax_u.place(-300);
    go(METH_19, 1'b0);
    repeat (10) @(posedge sys_clk);
    clk_en <= 1'b0;
    repeat (100) @(posedge sys_clk);
    clk_en <= 1'b1;
    #1;
    chk_bit(status.busy, 1'b1);
    chk_bit(motion.dir_pos, 1'b1);
    chk_spd(motion.speed, fast_speed);
    wait_end();
    chk_bit(status.done, 1'b1);
  endtask : t_freeze
  task t_m19_21;
    home_case(METH_19, -300, 1'b0, 0, 1'b0, 1'b0);
    home_case(METH_19, 100, 1'b0, 0, 1'b0, 1'b1);
    home_case(METH_20, -300, 1'b0, 0, 1'b1, 1'b0);
    home_case(METH_20, 100, 1'b0, 0, 1'b1, 1'b0);
    home_case(METH_21, 300, 1'b0, 200, 1'b1, 1'b0);
    home_case(METH_21, 100, 1'b0, 200, 1'b1, 1'b0);
  endtask : t_m19_21
  // Second negative limit after the automatic reversal
  task t_second_limit;
    alarm_case(METH_13, -300, 1'b0, 250, 1'b1, 1'b0, 1'b1);
  endtask : t_second_limit
  task t_limit_abort;
    alarm_case(METH_19, -300, 1'b0, 20, 1'b0, 1'b1, 1'b1);
    alarm_case(METH_20, -300, 1'b0, 20, 1'b1, 1'b0, 1'b1);
    alarm_case(METH_21, 300, 1'b0, 20, 1'b1, 1'b0, 1'b0);
  endtask : t_limit_abort

  task print_verdict;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  // Main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_reserved();
    t_m13();
    t_m14();
    t_m17_18();
    t_m18_on();
    t_m19_21();
    t_freeze();
    t_second_limit();
    t_limit_abort();
    print_verdict();
  end
endmodule : tb
